// ==== rtl/digit_router.sv ====
// one selection digit steering one function from a chosen input
// assumes inputs are already synchronised to clk
`timescale 1ns/10ps
`default_nettype none
module digit_router #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic resetn,
  route_if.router rt
);
  localparam int IW = $clog2(N);

  // ---------------------------------------------------------------
  // selection
  // ---------------------------------------------------------------
  logic sel_valid;
  logic picked;
  logic active_r;
  assign sel_valid = (rt.sel < input_route_pkg::DIGIT_INACTIVE);
  assign picked = sel_valid & rt.inputs[rt.sel[IW-1:0]];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      active_r <= 1'b0;
    end else begin
      active_r <= picked;
    end
  end
  assign rt.active = active_r;
endmodule // digit_router
`default_nettype wire

// ==== rtl/input_route_pkg.sv ====
// shared constants for the four-digit input routing block
// assumes a 32-bit AXI4-Lite register bus and eight connector inputs
package input_route_pkg;
  localparam int ADDR_W = 12;
  localparam int DIGIT_W = 4;
  localparam int NUM_INPUTS = 8;
  localparam int SEL_W = 16;

  // byte addresses of the registers
  localparam logic [11:0] ADDR_ROUTE_SELECT = 12'h000;
  localparam logic [11:0] ADDR_ROUTE_ACTIVE = 12'h004;
  localparam logic [11:0] ADDR_RESTART = 12'h008;

  localparam logic [15:0] ROUTE_RESET = 16'h8888;
  localparam logic [3:0] DIGIT_INACTIVE = 4'h8;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  // digit positions inside the selection word, and the bit position of the restart register
  localparam int DIR_DIGIT_LSB = 0;
  localparam int SPD_DIGIT_LSB = 4;
  localparam int RESTART_BIT = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// ==== rtl/input_route_select_three.sv ====
// top of the connector input router with its AXI4-Lite register slave
// assumes GENERAL_IN comes from pins and is asynchronous to CORE_CLK
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module input_route_select_three #(
  parameter int N_IN = input_route_pkg::NUM_INPUTS
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [N_IN-1:0] GENERAL_IN,
  output logic ROTATION_DIRECTION_SWITCH_IN,
  output logic SPEED_SELECT_A_IN
);

  // ---------------------------------------------------------------
  // input synchroniser
  // ---------------------------------------------------------------
  logic [N_IN-1:0] in_meta_r;
  logic [N_IN-1:0] in_sync_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      in_meta_r <= '0;
      in_sync_r <= '0;
    end else begin
      in_meta_r <= GENERAL_IN;
      in_sync_r <= in_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // write channel capture
  // ---------------------------------------------------------------
  logic aw_full_r;
  logic w_full_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic aw_take;
  logic w_take;
  logic wr_fire;

  assign S_AXI_AWREADY = !aw_full_r && !bvalid_r;
  assign S_AXI_WREADY = !w_full_r && !bvalid_r;
  assign aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_take = S_AXI_WVALID && S_AXI_WREADY;
  assign wr_fire = aw_full_r && w_full_r && !bvalid_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (aw_take) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      w_full_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (w_take) begin
      w_full_r <= 1'b1;
      w_data_r <= S_AXI_WDATA;
      w_strb_r <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_full_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // write decode and parameter storage
  // ---------------------------------------------------------------
  logic [15:0] sel_r;
  logic [15:0] sel_nxt;
  logic [15:0] act_r;
  logic [15:0] wr_merged;
  logic wr_hit_sel;
  logic wr_hit_act;
  logic wr_hit_rst;
  logic wr_digits_ok;
  logic wr_sel_ok;
  logic apply_nxt;
  logic [1:0] bresp_nxt;

  // each nibble of the stored word must be a decimal digit
  function automatic logic digits_decimal(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (v[i*input_route_pkg::DIGIT_W +: input_route_pkg::DIGIT_W] >
          input_route_pkg::DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  assign wr_hit_sel = (aw_addr_r[11:2] == input_route_pkg::ADDR_ROUTE_SELECT[11:2]);
  assign wr_hit_act = (aw_addr_r[11:2] == input_route_pkg::ADDR_ROUTE_ACTIVE[11:2]);
  assign wr_hit_rst = (aw_addr_r[11:2] == input_route_pkg::ADDR_RESTART[11:2]);
  assign wr_merged = {(w_strb_r[1] ? w_data_r[15:8] : sel_r[15:8]),
                      (w_strb_r[0] ? w_data_r[7:0] : sel_r[7:0])};
  assign wr_digits_ok = digits_decimal(wr_merged);
  assign wr_sel_ok = wr_fire && wr_hit_sel && wr_digits_ok;
  assign sel_nxt = wr_sel_ok ? wr_merged : sel_r;
  // a restart request stands in for the power cycle
  assign apply_nxt = wr_fire && wr_hit_rst && w_strb_r[0] &&
                     w_data_r[input_route_pkg::RESTART_BIT];
  assign bresp_nxt = ((wr_hit_sel && wr_digits_ok) || wr_hit_act || wr_hit_rst) ?
                     input_route_pkg::RESP_OKAY : input_route_pkg::RESP_SLVERR;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      sel_r <= input_route_pkg::ROUTE_RESET;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // routing in use follows the stored word only at restart
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      act_r <= input_route_pkg::ROUTE_RESET;
    end else if (apply_nxt) begin
      act_r <= sel_r;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      bvalid_r <= 1'b0;
      bresp_r <= input_route_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= bresp_nxt;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic ar_take;
  logic rd_hit_sel;
  logic rd_hit_act;
  logic rd_hit_rst;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_nxt;

  assign S_AXI_ARREADY = !rvalid_r;
  assign ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_hit_sel = (S_AXI_ARADDR[11:2] == input_route_pkg::ADDR_ROUTE_SELECT[11:2]);
  assign rd_hit_act = (S_AXI_ARADDR[11:2] == input_route_pkg::ADDR_ROUTE_ACTIVE[11:2]);
  assign rd_hit_rst = (S_AXI_ARADDR[11:2] == input_route_pkg::ADDR_RESTART[11:2]);
  assign rdata_nxt = rd_hit_sel ? {16'h0000, sel_r} :
                     rd_hit_act ? {16'h0000, act_r} :
                     input_route_pkg::RDATA_ZERO;
  assign rresp_nxt = (rd_hit_sel || rd_hit_act || rd_hit_rst) ?
                     input_route_pkg::RESP_OKAY : input_route_pkg::RESP_SLVERR;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      rvalid_r <= 1'b0;
      rdata_r <= input_route_pkg::RDATA_ZERO;
      rresp_r <= input_route_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // ---------------------------------------------------------------
  // function routing
  // ---------------------------------------------------------------
  route_if #(.N(N_IN)) dir_rt ();
  route_if #(.N(N_IN)) spd_rt ();

  assign dir_rt.inputs = in_sync_r;
  assign dir_rt.sel = act_r[input_route_pkg::DIR_DIGIT_LSB +: input_route_pkg::DIGIT_W];
  assign spd_rt.inputs = in_sync_r;
  assign spd_rt.sel = act_r[input_route_pkg::SPD_DIGIT_LSB +: input_route_pkg::DIGIT_W];

  digit_router #(.N(N_IN)) u_dir (
    .clk(CORE_CLK),
    .resetn(RESETN),
    .rt(dir_rt.router)
  );

  digit_router #(.N(N_IN)) u_spd (
    .clk(CORE_CLK),
    .resetn(RESETN),
    .rt(spd_rt.router)
  );

  assign ROTATION_DIRECTION_SWITCH_IN = dir_rt.active;
  assign SPEED_SELECT_A_IN = spd_rt.active;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [3:0] dir_digit;
  logic [3:0] spd_digit;
  logic dir_pick;
  logic spd_pick;
  assign dir_digit = act_r[input_route_pkg::DIR_DIGIT_LSB +: input_route_pkg::DIGIT_W];
  assign spd_digit = act_r[input_route_pkg::SPD_DIGIT_LSB +: input_route_pkg::DIGIT_W];
  assign dir_pick = in_sync_r[dir_digit[2:0]];
  assign spd_pick = in_sync_r[spd_digit[2:0]];

  chk_dir_follows_input: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (dir_digit < input_route_pkg::DIGIT_INACTIVE) ##1 RESETN |->
      (ROTATION_DIRECTION_SWITCH_IN == $past(dir_pick)))
    else $error("direction output does not follow selected input");

  chk_dir_digit_only: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    ($stable(dir_digit) && $stable(in_sync_r) && !$stable(spd_digit)) |=>
      $stable(ROTATION_DIRECTION_SWITCH_IN))
    else $error("direction output moved without its own cause");

  chk_dir_forced_off: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (dir_digit >= input_route_pkg::DIGIT_INACTIVE) |=> !ROTATION_DIRECTION_SWITCH_IN)
    else $error("direction output active with inactive digit");

  chk_spd_forced_off: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (spd_digit > input_route_pkg::DIGIT_INACTIVE) |=> !SPEED_SELECT_A_IN)
    else $error("speed output active with undefined digit");

  chk_spd_follows_input: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (spd_digit < input_route_pkg::DIGIT_INACTIVE) |=> (SPEED_SELECT_A_IN == $past(spd_pick)))
    else $error("speed output does not follow selected input");

  chk_reset_value: assert property (@(posedge CORE_CLK)
    (!RESETN ##1 RESETN) |-> (sel_r == input_route_pkg::ROUTE_RESET) &&
      (act_r == input_route_pkg::ROUTE_RESET) && !ROTATION_DIRECTION_SWITCH_IN)
    else $error("selection word not at reset value");

  chk_range_guard: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (wr_fire && wr_hit_sel && !wr_digits_ok) |=>
      (sel_r == $past(sel_r)) && (S_AXI_BRESP == input_route_pkg::RESP_SLVERR))
    else $error("out of range value was stored");

  chk_apply_restart: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !apply_nxt |=> (act_r == $past(act_r)))
    else $error("routing changed without a restart");

  chk_apply_copies: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    apply_nxt |=> (act_r == $past(sel_r)))
    else $error("restart did not load the stored word");
endmodule // input_route_select_three
`default_nettype wire

// ==== rtl/route_if.sv ====
// carrier between the register side and one digit router
// assumes the owner drives inputs and sel on the same clock as the router
`timescale 1ns/10ps
`default_nettype none
interface route_if #(parameter int N = 8);
  logic [N-1:0] inputs;
  logic [3:0] sel;
  logic active;
  modport router(input inputs, input sel, output active);
  modport owner(output inputs, output sel, input active);
endinterface
`default_nettype wire

// ==== test/input_route_select_three_tb_top.sv ====
// self-checking bench for the connector input router
// assumes the design package and a 40 MHz clock with synchronous reset
`timescale 1ns/10ps
`default_nettype none
module input_route_select_three_tb_top;
  localparam logic [1:0] OK = input_route_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = input_route_pkg::RESP_SLVERR;
  logic clk, rstn, awv, wv, bry, arv, rry, awr, wrdy, bv, arr, rv, dsw, spa;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0] ws;
  logic [1:0] br, rr;
  logic [7:0] want;
  wire logic [7:0] sw;
  int n_fail, comparisons;

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  input_route_select_three i_dut (.CORE_CLK(clk), .RESETN(rstn),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .GENERAL_IN(sw), .ROTATION_DIRECTION_SWITCH_IN(dsw), .SPEED_SELECT_A_IN(spa));

  switch_bank i_sw (.clk(clk), .want(want), .sw(sw));

  // ----
  // reporting
  // ----
  task complete_run;
    begin
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task cmp_word(input logic [31:0] g, input logic [31:0] e);
    begin
      comparisons++;
      if (g !== e) begin
        n_fail++;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  task cmp_pin(input logic [1:0] g, input logic [1:0] e);
    begin
      comparisons++;
      if (g !== e) begin
        n_fail++;
        $display("CHECK FAILED t=%0t pins got %h exp %h", $time, g, e);
      end
    end
  endtask

  // ----
  // bus cycles
  // ----
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w, got;
    begin
      @(posedge clk);
      awa <= a;
      wd <= d;
      ws <= 4'hF;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      aw = 1;
      w = 1;
      got = 0;
      n = 0;
      while (n < 50 && !got) begin
        @(posedge clk);
        n++;
        if (!aw && !w && bv === 1'b1) begin
          got = 1;
        end else begin
          if (aw && awr === 1'b1) begin
            aw = 0;
            awv <= 0;
          end
          if (w && wrdy === 1'b1) begin
            w = 0;
            wv <= 0;
          end
        end
      end
      if (!got) begin
        n_fail++;
        complete_run();
      end else begin
        cmp_word(32'(br), 32'(er));
        bry <= 0;
      end
    end
  endtask

  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ar, got;
    begin
      @(posedge clk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      ar = 1;
      got = 0;
      n = 0;
      while (n < 50 && !got) begin
        @(posedge clk);
        n++;
        if (!ar && rv === 1'b1) begin
          got = 1;
        end else if (ar && arr === 1'b1) begin
          ar = 0;
          arv <= 0;
        end
      end
      if (!got) begin
        n_fail++;
        complete_run();
      end else begin
        cmp_word(rdat, ed);
        cmp_word(32'(rr), 32'(er));
        rry <= 0;
      end
    end
  endtask

  // set the switches, let them pass the synchroniser, then look at both functions
  task pins(input logic [7:0] v, input logic [1:0] e);
    begin
      @(posedge clk);
      want <= v;
      repeat (5) @(posedge clk);
      cmp_pin({dsw, spa}, e);
    end
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    rstn = 0;
    awv = 0;
    wv = 0;
    bry = 0;
    arv = 0;
    rry = 0;
    awa = 0;
    ara = 0;
    wd = 0;
    ws = 0;
    want = 8'hFF;
    n_fail = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    rstn <= 1;
    rd(12'h000, 32'h0000_8888, OK);
    rd(12'h004, 32'h0000_8888, OK);
    pins(8'hFF, 2'b00);
    wr(12'h000, 32'h0000_8853, OK);
    pins(8'hFF, 2'b00);
    rd(12'h004, 32'h0000_8888, OK);
    wr(12'h008, 32'h0000_0001, OK);
    rd(12'h004, 32'h0000_8853, OK);
    for (int i = 0; i < 8; i++) begin
      pins(8'(1 << i), {i == 3, i == 5});
    end
    // direction digit runs 9 down to 0 while the speed digit runs 0 up to 9
    for (int d = 0; d < 10; d++) begin
      wr(12'h000, {16'h0000, 8'h88, 4'(d), 4'(9 - d)}, OK);
      wr(12'h008, 32'h0000_0001, OK);
      pins(8'hFF, {(9 - d) < 8, d < 8});
      pins(8'(1 << d), {1'b0, d < 8});
    end
    wr(12'h000, 32'h0000_88A0, ERR);
    rd(12'h000, 32'h0000_8890, OK);
    // only the speed digit moves here, the direction digit stays at input 0
    wr(12'h000, 32'h0000_8850, OK);
    wr(12'h004, 32'h0000_1234, OK);
    rd(12'h004, 32'h0000_8890, OK);
    wr(12'h008, 32'h0000_0000, OK);
    rd(12'h004, 32'h0000_8890, OK);
    wr(12'h008, 32'h0000_0001, OK);
    rd(12'h004, 32'h0000_8850, OK);
    pins(8'h01, 2'b10);
    pins(8'h20, 2'b01);
    wr(12'h00C, 32'h0000_0001, ERR);
    rd(12'h00C, 32'h0000_0000, ERR);
    @(posedge clk);
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    rd(12'h004, 32'h0000_8888, OK);
    pins(8'hFF, 2'b00);
    complete_run();
  end
endmodule // input_route_select_three_tb_top
`default_nettype wire

// ==== test/switch_bank.sv ====
// connector switch bank standing in for the host's digital outputs
// assumes the bench sets the wanted pattern on the clock edge
`timescale 1ns/10ps
`default_nettype none
module switch_bank (
  input wire logic clk,
  input wire logic [7:0] want,
  output var logic [7:0] sw
);
  // contacts settle one cycle after they are commanded, high = closed
  always_ff @(posedge clk) begin
    sw <= want;
  end
endmodule // switch_bank
`default_nettype wire
